// ===== owd_pkg.sv
package owd_pkg;

  // ---------------------------------------------------------------------
  // Option word layout
  // ---------------------------------------------------------------------
  localparam int WORD_W = 13;

  localparam int W0_POWER_BIT = 12;
  localparam int W0_PULSE_BIT = 11;
  localparam int W0_FILTER_N_BIT = 10;
  localparam int W0_RESET_PIN_BIT = 9;
  localparam int W0_WATCHDOG_BIT = 6;
  localparam int W0_OSC_HI = 5;
  localparam int W0_OSC_LO = 3;
  localparam int W0_PROT_HI = 2;
  localparam int W0_PROT_LO = 0;
  localparam logic [12:0] W0_UNUSED_MASK = 13'h0180;

  localparam int W1_SOURCE_BIT = 12;
  localparam int W1_TIMER_PIN_BIT = 11;
  localparam int W1_TRIM_HI = 10;
  localparam int W1_TRIM_LO = 4;
  localparam int W1_FREQ_HI = 3;
  localparam int W1_FREQ_LO = 2;
  localparam int W1_LVR_HI = 1;
  localparam int W1_LVR_LO = 0;

  localparam int W2_SUB_TRIM_HI = 12;
  localparam int W2_SUB_TRIM_LO = 8;
  localparam int W2_LPF_BIT = 7;
  localparam int W2_SUB_RATE_BIT = 4;
  localparam int W2_REGULATOR_BIT = 3;
  localparam logic [12:0] W2_UNUSED_MASK = 13'h0067;

  // ---------------------------------------------------------------------
  // Values the outputs show until the words are loaded
  // ---------------------------------------------------------------------
  localparam logic [12:0] W0_DEFAULT = 13'h0020;
  localparam logic [12:0] W1_DEFAULT = 13'h0000;
  localparam logic [12:0] W2_DEFAULT = 13'h0080;

  // ---------------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------------
  localparam logic [2:0] OSC_CRYSTAL_MID_BAND = 3'h0;
  localparam logic [2:0] OSC_CRYSTAL_HIGH_BAND_ONE = 3'h1;
  localparam logic [2:0] OSC_CRYSTAL_LOW_BAND = 3'h2;
  localparam logic [2:0] OSC_RESERVED_A = 3'h3;
  localparam logic [2:0] OSC_RC_PORT_PIN = 3'h4;
  localparam logic [2:0] OSC_RC_CLOCK_OUT = 3'h5;
  localparam logic [2:0] OSC_CRYSTAL_HIGH_BAND_TWO = 3'h6;
  localparam logic [2:0] OSC_RESERVED_B = 3'h7;
  localparam logic [2:0] PROTECT_ON_CODE = 3'h7;
  localparam logic [1:0] RC_FREQ_4MHZ = 2'h0;
  localparam logic [1:0] RC_FREQ_1MHZ = 2'h1;
  localparam logic [1:0] RC_FREQ_8MHZ = 2'h2;
  localparam logic [1:0] RC_FREQ_455KHZ = 2'h3;
  localparam logic [1:0] LVR_OFF = 2'h0;

  // ---------------------------------------------------------------------
  // Load sequencing
  // ---------------------------------------------------------------------
  localparam logic [2:0] LOAD_SETTLE_CYCLES = 3'h4;

  typedef enum logic [1:0] {
    LD_SETTLE,
    LD_CAPTURE,
    LD_RUN
  } owd_load_state_t;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_RC_FREQ = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int SOFT_FREQ_HI = 7;
  localparam int SOFT_FREQ_LO = 6;
  localparam logic [1:0] SOFT_FREQ_RESET = 2'h0;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_SOURCE_BIT = 1;
  localparam int ST_FREQ_HI = 3;
  localparam int ST_FREQ_LO = 2;
  localparam int ST_UNUSED_BIT = 4;

endpackage

// ===== owd_sync.sv
`timescale 1ns/1ps

module owd_sync #(
  parameter int W = 13
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q,
  output logic o_agree
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  logic agree_reg;
  logic agree_next;

  // ---------------------------------------------------------------------
  // Three stages per bit; a new level counts once stages two and three
  // agree, so a bit caught mid-change is never taken.
  // ---------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        q_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : q_reg[g];
      end

      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
          q_reg[g] <= 1'b0;
        end else begin
          s1_reg[g] <= i_d[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          q_reg[g] <= q_next[g];
        end
      end
    end
  endgenerate

  always_comb begin
    agree_next = (s2_reg == s3_reg);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      agree_reg <= 1'b0;
    end else begin
      agree_reg <= agree_next;
    end
  end

  assign o_q = q_reg;
  assign o_agree = agree_reg;

endmodule // owd_sync

// ===== owd_wb_regs.sv
`timescale 1ns/1ps

module owd_wb_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cyc,
  input wire logic i_stb,
  input wire logic i_we,
  input wire logic [7:0] i_adr,
  input wire logic [3:0] i_sel,
  input wire logic [31:0] i_dat,
  input wire logic i_load_done,
  input wire logic i_source_select,
  input wire logic [1:0] i_freq_effective,
  input wire logic i_unused_set,
  output logic o_ack,
  output logic [31:0] o_dat,
  output logic [1:0] o_soft_freq
);

  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [1:0] soft_freq_reg;
  logic [1:0] soft_freq_next;
  logic req;

  // ---------------------------------------------------------------------
  // Classic cycle: ack one cycle after the request, dropped after one.
  // Only the run-time frequency byte and a status word are mapped; the
  // option words themselves never appear on this bus.
  // ---------------------------------------------------------------------
  always_comb begin
    req = i_cyc && i_stb && !ack_reg;
    ack_next = req;
    dat_next = 32'h0000_0000;
    soft_freq_next = soft_freq_reg;
    if (req && i_we && i_sel[0] && (i_adr == owd_pkg::REG_RC_FREQ)) begin
      soft_freq_next = i_dat[owd_pkg::SOFT_FREQ_HI:owd_pkg::SOFT_FREQ_LO];
    end
    if (req && !i_we) begin
      case (i_adr)
        owd_pkg::REG_RC_FREQ: begin
          dat_next[owd_pkg::SOFT_FREQ_HI:owd_pkg::SOFT_FREQ_LO] =
            soft_freq_reg;
        end
        owd_pkg::REG_STATUS: begin
          dat_next[owd_pkg::ST_DONE_BIT] = i_load_done;
          dat_next[owd_pkg::ST_SOURCE_BIT] = i_source_select;
          dat_next[owd_pkg::ST_FREQ_HI:owd_pkg::ST_FREQ_LO] =
            i_freq_effective;
          dat_next[owd_pkg::ST_UNUSED_BIT] = i_unused_set;
        end
        default: begin
          dat_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      soft_freq_reg <= owd_pkg::SOFT_FREQ_RESET;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      soft_freq_reg <= soft_freq_next;
    end
  end

  assign o_ack = ack_reg;
  assign o_dat = dat_reg;
  assign o_soft_freq = soft_freq_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_no_option_leak: assert property (
    o_ack |-> (o_dat[31:8] == 24'h00_0000))
    else $error("Read data carries bits above the mapped fields.");

endmodule // owd_wb_regs

// ===== owd_top.sv
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps

module owd_top (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic [12:0] I_OPTION_WORD0,
  input wire logic [12:0] I_OPTION_WORD1,
  input wire logic [12:0] I_OPTION_WORD2,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic O_WB_ACK,
  output logic [31:0] O_WB_DAT,
  output logic O_LOAD_DONE,
  output logic O_POWER_MODE_SELECT,
  output logic O_NOISE_PULSE_WIDTH_SELECT,
  output logic O_NOISE_FILTER_ENABLE_N,
  output logic O_RESET_PIN_ASSIGN,
  output logic O_WATCHDOG_ON,
  output logic [2:0] O_OSCILLATOR_MODE_FIELD,
  output logic O_INTERNAL_RC_OSCILLATOR,
  output logic O_RC_CLOCK_OUTPUT,
  output logic O_OSC_MODE_RESERVED,
  output logic O_CODE_PROTECT_ON,
  output logic O_RC_FREQ_SOURCE_SELECT,
  output logic O_TIMER_CLOCK_PIN_ASSIGN,
  output logic [6:0] O_RC_TRIM_CODE,
  output logic [1:0] O_RC_FREQ_FIELD,
  output logic [1:0] O_LOW_VOLTAGE_RESET_LEVEL,
  output logic [4:0] O_SUB_CLOCK_TRIM_CODE,
  output logic O_INPUT_FILTER_STRENGTH,
  output logic O_SUB_CLOCK_RATE_SELECT,
  output logic O_RC_REGULATOR_ON,
  output logic O_UNUSED_BITS_SET
);

  localparam int W = owd_pkg::WORD_W;

  logic [3*W-1:0] raw_words;
  logic [3*W-1:0] sync_words;
  logic sync_agree;
  logic [1:0] soft_freq;

  owd_pkg::owd_load_state_t state_reg;
  owd_pkg::owd_load_state_t state_next;
  logic [2:0] settle_reg;
  logic [2:0] settle_next;
  logic done_reg;
  logic done_next;

  logic [W-1:0] w0_reg;
  logic [W-1:0] w0_next;
  logic [W-1:0] w1_reg;
  logic [W-1:0] w1_next;
  logic [W-1:0] w2_reg;
  logic [W-1:0] w2_next;

  logic [1:0] freq_reg;
  logic [1:0] freq_next;

  // ---------------------------------------------------------------------
  // Option words from the nonvolatile array
  // ---------------------------------------------------------------------
  assign raw_words = {I_OPTION_WORD2, I_OPTION_WORD1, I_OPTION_WORD0};

  owd_sync #(
    .W(3 * W)
  ) u_sync (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_d(raw_words),
    .o_q(sync_words),
    .o_agree(sync_agree)
  );

  // ---------------------------------------------------------------------
  // Load sequencer
  // ---------------------------------------------------------------------
  // The words cannot be caught by the asynchronous reset itself, so they
  // are taken once after release and then frozen until the next reset.
  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    done_next = done_reg;
    w0_next = w0_reg;
    w1_next = w1_reg;
    w2_next = w2_reg;
    case (state_reg)
      owd_pkg::LD_SETTLE: begin
        settle_next = settle_reg + 3'h1;
        if (settle_reg == owd_pkg::LOAD_SETTLE_CYCLES - 3'h1) begin
          state_next = owd_pkg::LD_CAPTURE;
        end
      end
      owd_pkg::LD_CAPTURE: begin
        if (sync_agree) begin
          w0_next = sync_words[W-1:0];
          w1_next = sync_words[2*W-1:W];
          w2_next = sync_words[3*W-1:2*W];
          done_next = 1'b1;
          state_next = owd_pkg::LD_RUN;
        end
      end
      owd_pkg::LD_RUN: begin
        state_next = owd_pkg::LD_RUN;
      end
      default: begin
        state_next = owd_pkg::LD_SETTLE;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= owd_pkg::LD_SETTLE;
      settle_reg <= 3'h0;
      done_reg <= 1'b0;
      w0_reg <= owd_pkg::W0_DEFAULT;
      w1_reg <= owd_pkg::W1_DEFAULT;
      w2_reg <= owd_pkg::W2_DEFAULT;
    end else begin
      state_reg <= state_next;
      settle_reg <= settle_next;
      done_reg <= done_next;
      w0_reg <= w0_next;
      w1_reg <= w1_next;
      w2_reg <= w2_next;
    end
  end

  // ---------------------------------------------------------------------
  // Decoded settings
  // ---------------------------------------------------------------------
  // Plain fields are slices of the held words; outputs other than O_LOAD_DONE, O_RC_FREQ_FIELD, the bus and the derived flags below map to word bits.
  assign O_LOAD_DONE = done_reg;
  assign O_POWER_MODE_SELECT = w0_reg[owd_pkg::W0_POWER_BIT];
  assign O_NOISE_PULSE_WIDTH_SELECT = w0_reg[owd_pkg::W0_PULSE_BIT];
  assign O_NOISE_FILTER_ENABLE_N = w0_reg[owd_pkg::W0_FILTER_N_BIT];
  assign O_RESET_PIN_ASSIGN = w0_reg[owd_pkg::W0_RESET_PIN_BIT];
  assign O_WATCHDOG_ON = w0_reg[owd_pkg::W0_WATCHDOG_BIT];
  assign O_OSCILLATOR_MODE_FIELD =
    w0_reg[owd_pkg::W0_OSC_HI:owd_pkg::W0_OSC_LO];
  assign O_RC_FREQ_SOURCE_SELECT = w1_reg[owd_pkg::W1_SOURCE_BIT];
  assign O_TIMER_CLOCK_PIN_ASSIGN = w1_reg[owd_pkg::W1_TIMER_PIN_BIT];
  assign O_RC_TRIM_CODE =
    w1_reg[owd_pkg::W1_TRIM_HI:owd_pkg::W1_TRIM_LO];
  assign O_LOW_VOLTAGE_RESET_LEVEL =
    w1_reg[owd_pkg::W1_LVR_HI:owd_pkg::W1_LVR_LO];
  assign O_SUB_CLOCK_TRIM_CODE =
    w2_reg[owd_pkg::W2_SUB_TRIM_HI:owd_pkg::W2_SUB_TRIM_LO];
  assign O_INPUT_FILTER_STRENGTH = w2_reg[owd_pkg::W2_LPF_BIT];
  assign O_SUB_CLOCK_RATE_SELECT = w2_reg[owd_pkg::W2_SUB_RATE_BIT];
  assign O_RC_REGULATOR_ON = w2_reg[owd_pkg::W2_REGULATOR_BIT];

  // Derived flags are registered from the next word values so that they
  // line up with the slices above to the cycle.
  logic rc_osc_reg;
  logic rc_osc_next;
  logic rc_out_reg;
  logic rc_out_next;
  logic osc_rsv_reg;
  logic osc_rsv_next;
  logic prot_reg;
  logic prot_next;
  logic unused_reg;
  logic unused_next;

  always_comb begin
    rc_osc_next = (w0_next[owd_pkg::W0_OSC_HI:owd_pkg::W0_OSC_LO] ==
                   owd_pkg::OSC_RC_PORT_PIN) ||
                  (w0_next[owd_pkg::W0_OSC_HI:owd_pkg::W0_OSC_LO] ==
                   owd_pkg::OSC_RC_CLOCK_OUT);
    rc_out_next = (w0_next[owd_pkg::W0_OSC_HI:owd_pkg::W0_OSC_LO] ==
                   owd_pkg::OSC_RC_CLOCK_OUT);
    osc_rsv_next = (w0_next[owd_pkg::W0_OSC_HI:owd_pkg::W0_OSC_LO] ==
                    owd_pkg::OSC_RESERVED_A) ||
                   (w0_next[owd_pkg::W0_OSC_HI:owd_pkg::W0_OSC_LO] ==
                    owd_pkg::OSC_RESERVED_B);
    // Only the full all-ones pattern locks readout; a partly programmed
    // field is treated as unprotected.
    prot_next = (w0_next[owd_pkg::W0_PROT_HI:owd_pkg::W0_PROT_LO] ==
                 owd_pkg::PROTECT_ON_CODE);
    // Spare bits are flagged, not acted on, so a bad programmer shows up.
    unused_next = |(w0_next & owd_pkg::W0_UNUSED_MASK) ||
                  |(w2_next & owd_pkg::W2_UNUSED_MASK);
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rc_osc_reg <= 1'b1;
      rc_out_reg <= 1'b0;
      osc_rsv_reg <= 1'b0;
      prot_reg <= 1'b0;
      unused_reg <= 1'b0;
    end else begin
      rc_osc_reg <= rc_osc_next;
      rc_out_reg <= rc_out_next;
      osc_rsv_reg <= osc_rsv_next;
      prot_reg <= prot_next;
      unused_reg <= unused_next;
    end
  end

  assign O_INTERNAL_RC_OSCILLATOR = rc_osc_reg;
  assign O_RC_CLOCK_OUTPUT = rc_out_reg;
  assign O_OSC_MODE_RESERVED = osc_rsv_reg;
  assign O_CODE_PROTECT_ON = prot_reg;
  assign O_UNUSED_BITS_SET = unused_reg;

  // ---------------------------------------------------------------------
  // RC frequency: option field, or the run-time register when selected
  // ---------------------------------------------------------------------
  always_comb begin
    if (w1_next[owd_pkg::W1_SOURCE_BIT]) begin
      freq_next = soft_freq;
    end else begin
      freq_next = w1_next[owd_pkg::W1_FREQ_HI:owd_pkg::W1_FREQ_LO];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      freq_reg <= owd_pkg::RC_FREQ_4MHZ;
    end else begin
      freq_reg <= freq_next;
    end
  end

  assign O_RC_FREQ_FIELD = freq_reg;

  // ---------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------
  owd_wb_regs u_regs (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_cyc(I_WB_CYC),
    .i_stb(I_WB_STB),
    .i_we(I_WB_WE),
    .i_adr(I_WB_ADR),
    .i_sel(I_WB_SEL),
    .i_dat(I_WB_DAT),
    .i_load_done(done_reg),
    .i_source_select(w1_reg[owd_pkg::W1_SOURCE_BIT]),
    .i_freq_effective(freq_reg),
    .i_unused_set(unused_reg),
    .o_ack(O_WB_ACK),
    .o_dat(O_WB_DAT),
    .o_soft_freq(soft_freq)
  );

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);

  chk_words_frozen: assert property (
    $past(done_reg) |-> $stable(w0_reg) && $stable(w1_reg) &&
      $stable(w2_reg))
    else $error("Option words changed after loading.");

  chk_load_takes_sync: assert property (
    (state_reg == owd_pkg::LD_CAPTURE) && sync_agree |=>
      done_reg && ({w2_reg, w1_reg, w0_reg} == $past(sync_words)))
    else $error("Capture did not take the synchronised words.");

  chk_settle_first: assert property (
    $rose(I_RST_N) |-> !done_reg [*4])
    else $error("Load finished before the settle time.");

  chk_power_bit: assert property (
    $rose(done_reg) |->
      O_POWER_MODE_SELECT == $past(sync_words[owd_pkg::W0_POWER_BIT]))
    else $error("Power mode does not follow word 0 bit 12.");

  chk_filter_bits: assert property (
    $rose(done_reg) |->
      {O_NOISE_PULSE_WIDTH_SELECT, O_NOISE_FILTER_ENABLE_N} ==
      $past(sync_words[owd_pkg::W0_PULSE_BIT:owd_pkg::W0_FILTER_N_BIT]))
    else $error("Noise filter settings do not follow word 0.");

  chk_rc_osc_mode: assert property (
    done_reg && $past(done_reg) |->
      O_INTERNAL_RC_OSCILLATOR == (w0_reg[5:4] == 2'h2) &&
      O_RC_CLOCK_OUTPUT == (w0_reg[5:3] == 3'h5))
    else $error("Oscillator decode wrong.");

  chk_protect: assert property (
    done_reg && $past(done_reg) |-> O_CODE_PROTECT_ON == (&w0_reg[2:0]))
    else $error("Code protect decode wrong.");

  chk_freq_source: assert property (
    done_reg && w1_reg[12] && $past(done_reg) |=>
      O_RC_FREQ_FIELD == $past(soft_freq))
    else $error("Run-time frequency source not followed.");

  chk_freq_option: assert property (
    done_reg && !w1_reg[12] |-> O_RC_FREQ_FIELD == w1_reg[3:2])
    else $error("Option frequency field not followed.");

  chk_lvr_level: assert property (
    $rose(done_reg) |->
      O_LOW_VOLTAGE_RESET_LEVEL == $past(sync_words[W+1:W]))
    else $error("Low-voltage reset level not followed.");

  chk_sub_clock: assert property (
    $rose(done_reg) |->
      {O_SUB_CLOCK_TRIM_CODE, O_INPUT_FILTER_STRENGTH} ==
      $past(sync_words[3*W-1:2*W+7]) &&
      O_SUB_CLOCK_RATE_SELECT == $past(sync_words[2*W+4]))
    else $error("Word 2 settings not followed.");

endmodule // owd_top

// ===== tb_top.sv
`timescale 1ns/1ps

module tb_top;

  // -------------------------------------------------------------------
  // Stimulus and observation
  // -------------------------------------------------------------------
  logic clk;
  logic rst_n;
  logic [12:0] w0, w1, w2, e0, e1, e2;
  logic [2:0] k;
  logic cyc, stb, we, ack, done, un_exp;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic pm, pw, fn, rp, wd, internal_rc_oscillator, rco, rsv, cp, src, tp, lpf, sr, reg_on, un;
  logic [2:0] osc;
  logic [6:0] trim;
  logic [1:0] frq, lvr;
  logic [4:0] strim;
  int err_count;
  int checked;
  int n;

  owd_top DUT (
    .I_CLOCK(clk), .I_RST_N(rst_n),
    .I_OPTION_WORD0(w0), .I_OPTION_WORD1(w1), .I_OPTION_WORD2(w2),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
    .O_LOAD_DONE(done), .O_POWER_MODE_SELECT(pm),
    .O_NOISE_PULSE_WIDTH_SELECT(pw), .O_NOISE_FILTER_ENABLE_N(fn),
    .O_RESET_PIN_ASSIGN(rp), .O_WATCHDOG_ON(wd),
    .O_OSCILLATOR_MODE_FIELD(osc), .O_INTERNAL_RC_OSCILLATOR(internal_rc_oscillator),
    .O_RC_CLOCK_OUTPUT(rco), .O_OSC_MODE_RESERVED(rsv),
    .O_CODE_PROTECT_ON(cp), .O_RC_FREQ_SOURCE_SELECT(src),
    .O_TIMER_CLOCK_PIN_ASSIGN(tp), .O_RC_TRIM_CODE(trim),
    .O_RC_FREQ_FIELD(frq), .O_LOW_VOLTAGE_RESET_LEVEL(lvr),
    .O_SUB_CLOCK_TRIM_CODE(strim), .O_INPUT_FILTER_STRENGTH(lpf),
    .O_SUB_CLOCK_RATE_SELECT(sr), .O_RC_REGULATOR_ON(reg_on),
    .O_UNUSED_BITS_SET(un)
  );

  always #50 clk = ~clk;

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Every decoded output against the words; s is the run-time frequency.
  task automatic check_all(input logic [12:0] a, input logic [12:0] b,
                           input logic [12:0] c, input logic [1:0] s,
                           input logic d);
    chk("done", d, done);
    chk("power", a[12], pm);
    chk("pulse", a[11], pw);
    chk("filter_n", a[10], fn);
    chk("reset_pin", a[9], rp);
    chk("watchdog", a[6], wd);
    chk("osc", a[5:3], osc);
    chk("irc", a[5:4] == 2'b10, internal_rc_oscillator);
    chk("rc_out", a[5:3] == 3'h5, rco);
    chk("osc_rsv", a[4:3] == 2'b11, rsv);
    chk("protect", a[2:0] == 3'h7, cp);
    chk("source", b[12], src);
    chk("timer_pin", b[11], tp);
    chk("trim", b[10:4], trim);
    chk("freq", b[12] ? s : b[3:2], frq);
    chk("lvr", b[1:0], lvr);
    chk("sub_trim", c[12:8], strim);
    chk("lpf", c[7], lpf);
    chk("sub_rate", c[4], sr);
    chk("regulator", c[3], reg_on);
    chk("spare", (|(a & owd_pkg::W0_UNUSED_MASK)) |
                 (|(c & owd_pkg::W2_UNUSED_MASK)), un);
  endtask

  // Classic single cycle; the request is held until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    q = rdat;
    if (t >= 20) begin
      err_count++;
      end_of_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'h1, 32'h0);
    chk("rdata", e, q);
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {w0, w1, w2} = '0;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    err_count = 0;
    checked = 0;
    // Eight word sets walk every oscillator, frequency and level code.
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      e0 = {k[0], k[1], k[2], ~k[0], 1'b0, k == 3'h6, k[1], k,
            k[0] ? 3'h7 : {1'b0, k[2:1]}};
      e1 = {k == 3'h7, k[0], 7'(i * 13 + 5), k[1:0], k[2:1]};
      e2 = {5'(i * 7 + 3), k[0], 1'b0, k == 3'h2, k[1], k[2], 3'h0};
      un_exp = (|(e0 & owd_pkg::W0_UNUSED_MASK)) |
               (|(e2 & owd_pkg::W2_UNUSED_MASK));
      @(posedge clk);
      rst_n <= 1'b0;
      w0 <= e0;
      w1 <= e1;
      w2 <= e2;
      repeat (8) @(posedge clk);
      @(negedge clk);
      check_all(owd_pkg::W0_DEFAULT, owd_pkg::W1_DEFAULT,
                owd_pkg::W2_DEFAULT, 2'h0, 1'b0);
      @(posedge clk);
      rst_n <= 1'b1;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (done !== 1'b1 && n < 30);
      if (n >= 30) begin
        err_count++;
        end_of_test();
      end
      check_all(e0, e1, e2, 2'h0, 1'b1);
      wb(1'b1, owd_pkg::REG_RC_FREQ, 4'h1, 32'hc0);
      rd(owd_pkg::REG_STATUS, {27'h0, un_exp,
         e1[12] ? 2'h3 : e1[3:2], e1[12], 1'b1});
      // Late pin changes must not reach the settings.
      @(posedge clk);
      w0 <= ~e0;
      w1 <= ~e1;
      w2 <= ~e2;
      repeat (8) @(posedge clk);
      @(negedge clk);
      check_all(e0, e1, e2, 2'h3, 1'b1);
    end
    // The last set takes its frequency from the run-time register.
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, owd_pkg::REG_RC_FREQ, 4'h1, 32'(c) << 6);
      @(negedge clk);
      chk("freq", 32'(c), frq);
      rd(owd_pkg::REG_RC_FREQ, 32'(c) << 6);
    end
    wb(1'b1, owd_pkg::REG_RC_FREQ, 4'h0, 32'h0);
    rd(owd_pkg::REG_RC_FREQ, 32'hc0);
    wb(1'b1, 8'h08, 4'h1, 32'hff);
    rd(8'h08, 32'h0);
    wb(1'b1, owd_pkg::REG_STATUS, 4'h1, 32'h0);
    rd(owd_pkg::REG_STATUS, 32'hf);
    end_of_test();
  end

endmodule // tb_top
